// ---- src/pbsp_params.svh ----
// constants for the pipelined burst memory port
`ifndef PBSP_PARAMS_SVH
`define PBSP_PARAMS_SVH
`define PBSP_ADDR_W         19
`define PBSP_BYTES          4
`define PBSP_BYTE_W         9
`define PBSP_BURST_W        2
`define PBSP_COUNT_ZERO     2'h0
`define PBSP_COUNT_STEP     2'h1
`define PBSP_ORDER_LINEAR   1'b0
`endif

// ---- src/pbsp_pkg.sv ----
// types for the pipelined burst memory port
`default_nettype none
package pbsp_pkg;
    typedef enum logic [1:0] {
        PBSP_ST_IDLE,
        PBSP_ST_ACTIVE,
        PBSP_ST_SLEEP
    } pbsp_state_t;
endpackage
`default_nettype wire

// ---- src/pbsp_mem.sv ----
// byte-sliced storage array with registered read data
`timescale 1ns/1ps
`default_nettype none
module pbsp_mem #(
    parameter int ADDR_W = 19,
    parameter int BYTES  = 4,
    parameter int BYTE_W = 9
) (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic [BYTES-1:0]          wr_en,
    input  wire logic [ADDR_W-1:0]         wr_addr,
    input  wire logic [BYTES*BYTE_W-1:0]   wr_data,
    input  wire logic [ADDR_W-1:0]         rd_addr,
    output logic      [BYTES*BYTE_W-1:0]   rd_data
);
    localparam int DEPTH = 1 << ADDR_W;

    // refuse shapes whose depth overflows the index or has no lanes
    if (ADDR_W < 1 || ADDR_W > 30 || BYTES < 1 || BYTE_W < 1) begin : g_bad_param
        $error("pbsp_mem: unsupported parameter values");
    end

    // one array per byte lane so each lane has a single writer
    for (genvar i = 0; i < BYTES; i++) begin : g_lane
        logic [BYTE_W-1:0] store [DEPTH];
        always_ff @(posedge clk) begin
            if (wr_en[i]) begin
                store[wr_addr] <= wr_data[i*BYTE_W +: BYTE_W];
            end
        end
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                rd_data[i*BYTE_W +: BYTE_W] <= '0;
            end else begin
                rd_data[i*BYTE_W +: BYTE_W] <= store[rd_addr]; // pipeline output register
            end
        end
    end
endmodule
`default_nettype wire

// ---- src/pbsp_port.sv ----
// synchronous control port of a pipelined burst static memory
`timescale 1ns/1ps
`default_nettype none
`include "pbsp_params.svh"
module pbsp_port #(
    parameter int ADDR_W = `PBSP_ADDR_W,
    parameter int BYTES  = `PBSP_BYTES,
    parameter int BYTE_W = `PBSP_BYTE_W
) (
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic [ADDR_W-1:0]         addr,
    input  wire logic                      processor_addr_strobe_n,
    input  wire logic                      controller_addr_strobe_n,
    input  wire logic                      burst_advance_n,
    input  wire logic                      global_write_n,
    input  wire logic                      byte_write_enable_n,
    input  wire logic [BYTES-1:0]          byte_write_select_n,
    input  wire logic                      chip_sel_first_n,
    input  wire logic                      chip_sel_second,
    input  wire logic                      chip_sel_third_n,
    input  wire logic                      output_enable_n,
    input  wire logic                      sleep_request,
    input  wire logic                      burst_order_strap,
    input  wire logic [BYTES*BYTE_W-1:0]   dq_in,
    output logic      [BYTES*BYTE_W-1:0]   dq_out,
    output logic                           dq_oe,
    output logic                           sleep_active
);
    localparam int BW = `PBSP_BURST_W;

    // refuse shapes the burst and lane logic cannot serve
    if (ADDR_W <= BW || BYTES < 1 || BYTE_W < 1) begin : g_bad_param
        $error("pbsp_port: unsupported parameter values");
    end

    pbsp_pkg::pbsp_state_t state_q, state_d;
    logic [ADDR_W-1:0] base_q, base_d;
    logic [BW-1:0]     start_q, start_d;
    logic [BW-1:0]     count_q, count_d;
    logic [ADDR_W-1:0] rd_addr_q, rd_addr_d;
    logic              first_q, first_d;
    logic              rd_q, rd_d;
    logic              oe_q, oe_d;
    logic              strap_q, strap_d;
    logic              sleep_q;
    logic              p_take, c_take, load, sel, acc_ok;
    logic [BW-1:0]     low;
    logic [ADDR_W-1:0] acc_addr;
    logic [BYTES-1:0]  wr_en;

    // strobe qualification and chip selection
    assign p_take = !processor_addr_strobe_n && !chip_sel_first_n;
    assign c_take = !controller_addr_strobe_n && !p_take;
    assign load   = p_take || c_take;
    assign sel    = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;

    // enables matter only on loads; bursts run on the held state
    assign acc_ok = !sleep_request && (load ? sel : (state_q == pbsp_pkg::PBSP_ST_ACTIVE));

    // write qualification per byte lane
    for (genvar i = 0; i < BYTES; i++) begin : g_wr
        assign wr_en[i] = acc_ok && (!global_write_n
                          || (!byte_write_enable_n && !byte_write_select_n[i]));
    end

    // next state of address, burst and output control
    always_comb begin
        state_d   = state_q;
        base_d    = base_q;
        start_d   = start_q;
        count_d   = count_q;
        first_d   = first_q;
        rd_addr_d = rd_addr_q;
        strap_d   = sys_rst ? burst_order_strap : strap_q;    // strap caught while in reset
        if (sleep_request) begin
            state_d = pbsp_pkg::PBSP_ST_SLEEP;
        end else if (load) begin
            if (sel) begin
                state_d = pbsp_pkg::PBSP_ST_ACTIVE;
                base_d  = addr;
                start_d = addr[BW-1:0];
                count_d = `PBSP_COUNT_ZERO;
                first_d = (state_q != pbsp_pkg::PBSP_ST_ACTIVE);
            end else begin
                state_d = pbsp_pkg::PBSP_ST_IDLE;
            end
        end else if (state_q == pbsp_pkg::PBSP_ST_SLEEP) begin
            state_d = pbsp_pkg::PBSP_ST_IDLE;
        end else if (state_q == pbsp_pkg::PBSP_ST_ACTIVE && !burst_advance_n) begin
            count_d = count_q + `PBSP_COUNT_STEP;
        end
        if (strap_q == `PBSP_ORDER_LINEAR) begin
            low = start_d + count_d;
        end else begin
            low = start_d ^ count_d;
        end
        acc_addr = {base_d[ADDR_W-1:BW], low};
        rd_d = acc_ok && (wr_en == '0);
        if (acc_ok) begin
            rd_addr_d = acc_addr;
        end
        if (rd_q && !(load && sel)) begin
            first_d = 1'b0;
        end
        oe_d = rd_q && !output_enable_n && !first_q && !sleep_request
               && !(load && !sel);
    end

    // register stage; all inputs taken on the rising edge
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q   <= pbsp_pkg::PBSP_ST_IDLE;
            base_q    <= '0;
            start_q   <= '0;
            count_q   <= '0;
            first_q   <= 1'b1;
            rd_q      <= 1'b0;
            oe_q      <= 1'b0;
            rd_addr_q <= '0;
            sleep_q   <= 1'b0;
        end else begin
            state_q   <= state_d;
            base_q    <= base_d;
            start_q   <= start_d;
            count_q   <= count_d;
            first_q   <= first_d;
            rd_q      <= rd_d;
            oe_q      <= oe_d;
            rd_addr_q <= rd_addr_d;
            sleep_q   <= sleep_request;
        end
        strap_q <= strap_d;
    end

    assign dq_oe        = oe_q;
    assign sleep_active = sleep_q;

    // storage; read data come from its output register
    pbsp_mem #(
        .ADDR_W (ADDR_W),
        .BYTES  (BYTES),
        .BYTE_W (BYTE_W)
    ) pbsp_mem_inst (
        .clk     (clk),
        .sys_rst (sys_rst),
        .wr_en   (wr_en),
        .wr_addr (acc_addr),
        .wr_data (dq_in),
        .rd_addr (rd_addr_q),
        .rd_data (dq_out)
    );

    // checks on the port behaviour
    a_deselect_release: assert property (@(posedge clk) disable iff (sys_rst)
        (load && !sel && !sleep_request) |=> !dq_oe && state_q == pbsp_pkg::PBSP_ST_IDLE)
        else $error("deselect did not release data");
    a_first_read_mask: assert property (@(posedge clk) disable iff (sys_rst)
        (load && sel && state_q == pbsp_pkg::PBSP_ST_IDLE && !sleep_request) |=> ##1 !dq_oe)
        else $error("first read after deselect drove data");
    a_oe_high_release: assert property (@(posedge clk) disable iff (sys_rst)
        output_enable_n |=> !dq_oe)
        else $error("data driven with output enable high");
    a_oe_read_drive: assert property (@(posedge clk) disable iff (sys_rst)
        (rd_q && !first_q && !output_enable_n && !sleep_request && !(load && !sel)) |=> dq_oe)
        else $error("read data not driven");
    a_burst_step: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == pbsp_pkg::PBSP_ST_ACTIVE && !load && !burst_advance_n && !sleep_request)
        |=> count_q == BW'($past(count_q) + `PBSP_COUNT_STEP))
        else $error("burst counter did not step");
    a_burst_hold: assert property (@(posedge clk) disable iff (sys_rst)
        (state_q == pbsp_pkg::PBSP_ST_ACTIVE && !load && burst_advance_n && !sleep_request)
        |=> $stable(count_q) && state_q == pbsp_pkg::PBSP_ST_ACTIVE)
        else $error("burst disturbed without load");
    a_load_start: assert property (@(posedge clk) disable iff (sys_rst)
        (load && sel && !sleep_request) |=> start_q == $past(addr[BW-1:0]) && count_q == '0
        && base_q == $past(addr))
        else $error("strobe did not load address");
    a_first_en_block: assert property (@(posedge clk) disable iff (sys_rst)
        (!processor_addr_strobe_n && chip_sel_first_n && controller_addr_strobe_n && !sleep_request)
        |=> $stable(base_q) && $stable(start_q))
        else $error("blocked processor strobe loaded");
    a_priority_proc: assert property (@(posedge clk) disable iff (sys_rst)
        (!processor_addr_strobe_n && !chip_sel_first_n) |-> p_take && !c_take)
        else $error("controller strobe took priority");
    a_global_write: assert property (@(posedge clk) disable iff (sys_rst)
        (acc_ok && !global_write_n) |-> wr_en == '1)
        else $error("global write missed a byte");
    a_byte_qualify: assert property (@(posedge clk) disable iff (sys_rst)
        (global_write_n && byte_write_enable_n) |-> wr_en == '0)
        else $error("byte written without byte enable");
    a_sleep_quiet: assert property (@(posedge clk) disable iff (sys_rst)
        sleep_request |-> wr_en == '0 ##1 !dq_oe && sleep_active)
        else $error("activity during sleep");
    a_read_address: assert property (@(posedge clk) disable iff (sys_rst)
        (acc_ok && !load && state_q == pbsp_pkg::PBSP_ST_ACTIVE) |=> rd_addr_q[BW-1:0] ==
        (strap_q == `PBSP_ORDER_LINEAR ? BW'(start_q + count_q) : (start_q ^ count_q)))
        else $error("burst address order wrong");

    c_full_burst: cover property (@(posedge clk) disable iff (sys_rst)
        (load && sel) ##1 (!burst_advance_n && !load) [*3]);
    c_deselect: cover property (@(posedge clk) disable iff (sys_rst)
        (state_q == pbsp_pkg::PBSP_ST_ACTIVE && load && !sel));
    c_sleep_exit: cover property (@(posedge clk) disable iff (sys_rst)
        sleep_request ##1 !sleep_request ##1 (load && sel));
    c_driven_read: cover property (@(posedge clk) disable iff (sys_rst) dq_oe);
endmodule
`default_nettype wire

// ---- tb/pbsp_host_model.sv ----
// processor side bus model that drives the memory port
`timescale 1ns/1ps
`default_nettype none
module pbsp_host_model (
    input  wire logic          clk,
    output logic      [13:0]   ctl,
    output logic      [5:0]    addr,
    output logic      [35:0]   dq
);
    // ctl: sleep, oe_n, enables 1/2/3, strobes p/c, advance, global, byte enable, byte selects
    initial begin
        ctl  = 14'h05FF;
        addr = 6'h00;
        dq   = 36'h0_0000_0000;
    end

    // one bus cycle: changed just after an edge, held until the next edge samples it
    task automatic op(input logic [13:0] c, input logic [5:0] a, input logic [35:0] d);
        @(posedge clk);
        ctl  <= c;
        addr <= a;
        // released data lines flip so no stale word looks valid
        dq   <= (c[5] && c[4]) ? ~dq : d;
        #2;
    endtask
endmodule
`default_nettype wire

// ---- tb/pbsp_port_tb_top.sv ----
// self-checking bench for the pipelined burst memory port
`timescale 1ns/1ps
`default_nettype none
module pbsp_port_tb_top;
    localparam logic [13:0] IDLE = 14'h05FF, LDC = 14'h057F, LDB = 14'h047F, ADVX = 14'h0BBF;
    localparam logic [13:0] WLD = 14'h055F, WADV = 14'h059F, BYTE0 = 14'h056E, BNOE = 14'h0570;
    localparam logic [13:0] PIGN = 14'h0CFF, PDES = 14'h0C7F, DES2 = 14'h017F, DES3 = 14'h077F;
    localparam logic [13:0] OEOFF = 14'h15FF, SLP = 14'h25FF, SLPW = 14'h255F;
    logic        clk;
    logic        sys_rst;
    logic        burst_order_strap;
    logic [13:0] ctl;
    logic [5:0]  addr;
    logic [35:0] dq_in;
    logic [35:0] dq_out;
    logic        dq_oe;
    logic        sleep_active;
    logic [35:0] exp_mem [64];
    int          failures;
    int          check_count;

    pbsp_host_model pbsp_host_model_inst (.clk(clk), .ctl(ctl), .addr(addr), .dq(dq_in));

    pbsp_port #(.ADDR_W(6)) pbsp_port_inst (
        .clk(clk), .sys_rst(sys_rst), .addr(addr),
        .processor_addr_strobe_n(ctl[8]), .controller_addr_strobe_n(ctl[7]),
        .burst_advance_n(ctl[6]), .global_write_n(ctl[5]), .byte_write_enable_n(ctl[4]),
        .byte_write_select_n(ctl[3:0]), .chip_sel_first_n(ctl[11]), .chip_sel_second(ctl[10]),
        .chip_sel_third_n(ctl[9]), .output_enable_n(ctl[12]), .sleep_request(ctl[13]),
        .burst_order_strap(burst_order_strap), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe), .sleep_active(sleep_active));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [5:0] nxt(input logic [5:0] b, input int k);
        nxt = burst_order_strap ? {b[5:2], b[1:0] ^ 2'(k)} : {b[5:2], b[1:0] + 2'(k)};
    endfunction

    function automatic logic [35:0] pat(input logic [5:0] a);
        pat = {4{3'h5, a}};
    endfunction

    task automatic chk36(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic op(input logic [13:0] c, input logic [5:0] a, input logic [35:0] d);
        pbsp_host_model_inst.op(c, a, d);
    endtask

    task automatic do_reset(input logic s);
        @(posedge clk);
        sys_rst <= 1'b1;
        burst_order_strap <= s;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    // global-write burst through the whole aligned group
    task automatic wr_burst(input logic [5:0] b);
        for (int k = 0; k < 4; k++) begin
            op(k == 0 ? WLD : WADV, b, pat(nxt(b, k)));
            exp_mem[nxt(b, k)] = pat(nxt(b, k));
        end
        op(IDLE, b, 36'h0_0000_0000);
    endtask

    // read burst with enables off while advancing, data one edge late
    task automatic rd_burst(input logic [13:0] ld, input logic [5:0] b, input logic first);
        for (int i = 0; i < 6; i++) begin
            op(i == 0 ? ld : (i < 4 ? ADVX : IDLE), b, 36'h0_0000_0000);
            if (i >= 2) chk36(dq_out, exp_mem[nxt(b, i - 2)]);
            if (i >= (first ? 1 : 2)) chk1(dq_oe, i >= (first ? 3 : 2));
        end
    endtask

    task automatic t_linear;
        wr_burst(6'h0A);
        op(IDLE, 6'h00, 36'h0_0000_0000);
        op(IDLE, 6'h00, 36'h0_0000_0000);
        op(DES2, 6'h00, 36'h0_0000_0000);
        chk1(dq_oe, 1'b1);
        op(IDLE, 6'h00, 36'h0_0000_0000);
        chk1(dq_oe, 1'b0);
        rd_burst(LDC, 6'h0A, 1'b1);
    endtask

    task automatic t_bytes;
        wr_burst(6'h20);
        op(BYTE0, 6'h20, 36'hF_FFFF_FFFF);
        exp_mem[6'h20][8:0] = 9'h1FF;
        op(BNOE, 6'h21, 36'h0_0000_0000);
        op(DES3, 6'h00, 36'h0_0000_0000);
        rd_burst(LDC, 6'h20, 1'b1);
    endtask

    task automatic t_deselect;
        op(PIGN, 6'h00, 36'h0_0000_0000);
        op(IDLE, 6'h00, 36'h0_0000_0000);
        chk1(dq_oe, 1'b1);
        op(OEOFF, 6'h00, 36'h0_0000_0000);
        op(IDLE, 6'h00, 36'h0_0000_0000);
        chk1(dq_oe, 1'b0);
        op(PDES, 6'h00, 36'h0_0000_0000);
        op(ADVX, 6'h00, 36'h0_0000_0000);
        chk1(dq_oe, 1'b0);
        op(ADVX, 6'h00, 36'h0_0000_0000);
        chk1(dq_oe, 1'b0);
        rd_burst(LDB, 6'h0A, 1'b1);
    endtask

    task automatic t_sleep;
        op(SLP, 6'h00, 36'h0_0000_0000);
        op(SLPW, 6'h20, 36'h0_0000_0000);
        chk1(sleep_active, 1'b1);
        op(SLP, 6'h00, 36'h0_0000_0000);
        op(IDLE, 6'h00, 36'h0_0000_0000);
        op(IDLE, 6'h00, 36'h0_0000_0000);
        chk1(sleep_active, 1'b0);
        rd_burst(LDC, 6'h20, 1'b1);
    endtask

    task automatic t_interleave;
        wr_burst(6'h31);
        op(DES2, 6'h00, 36'h0_0000_0000);
        rd_burst(LDC, 6'h31, 1'b1);
    endtask

    task automatic tally_and_finish;
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        sys_rst = 1'b1;
        burst_order_strap = 1'b0;
        failures = 0;
        check_count = 0;
        do_reset(1'b0);
        t_linear();
        t_bytes();
        t_deselect();
        t_sleep();
        do_reset(1'b1);
        t_interleave();
        tally_and_finish();
    end

    // watchdog against a hang
    initial begin
        repeat (2000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
